//--- verilog/err_irq_cfg.svh
// Overview of operation
// - Multi-error enable: interrupt on every logged error while err_irq_en is set
// - Self-test fail has no effect; multi-error enable setting still applies
// - Enable clear: interrupt only if summary clear
// - Enable clear: suppress interrupts while error outstanding
// - Vector disable set: never return stored vector
// - Vector disabled: answer identify with read error
// - Bit zero reserved, reads zero, write zero
// - Vector enabled: reply with vector bits 15:2
`ifndef ERR_IRQ_CFG_SVH
`define ERR_IRQ_CFG_SVH
`define ADDR_W            4
`define OFF_CTRL_STATUS   4'h0
`define OFF_RETURN_VECTOR 4'h4
`define OFF_BUS_ERROR     4'h8
`define OFF_IRQ_STATUS    4'hC
`define OFF_IRQ_MASK      4'hC
`define BIT_VEC_DIS       1
`define BIT_MULTI_ERROR_IRQ_ENABLE        3
`define BIT_SUMMARY       31
`define BIT_SELFTEST      10
`define VEC_HI            15
`define VEC_LO            2
`define IRQ_ERR           0
`define IRQ_IDENT         1
`define IRQ_W             2
`endif

//--- verilog/err_irq_pkg.sv
package err_irq_pkg;
    typedef enum logic [2:0]
    {
        RSP_IDLE   = 3'b001,
        RSP_VECTOR = 3'b010,
        RSP_RDERR  = 3'b100
    } ident_rsp_e;
endpackage : err_irq_pkg

//--- verilog/ident_responder.sv
`timescale 1ns/100ps
`include "err_irq_cfg.svh"
module ident_responder
    import err_irq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ident_req,
    input  wire logic        vec_dis,
    input  wire logic [13:0] vec_value,
    output logic             rsp_valid_ff,
    output logic             rsp_rderr_ff,
    output logic [31:0]      rsp_data_ff
);
    ident_rsp_e  state_ff;
    ident_rsp_e  nxt_state;
    logic        nxt_valid;
    logic        nxt_rderr;
    logic [31:0] nxt_data;

    always_comb
    begin
        nxt_state = RSP_IDLE;
        nxt_valid = 1'b0;
        nxt_rderr = 1'b0;
        nxt_data  = 32'h0;
        case (state_ff)
            RSP_IDLE:
            begin
                if (ident_req)
                begin
                    nxt_valid = 1'b1;
                    if (vec_dis)
                    begin
                        nxt_state = RSP_RDERR;
                        nxt_rderr = 1'b1;
                    end
                    else
                    begin
                        nxt_state = RSP_VECTOR;
                        nxt_data[`VEC_HI:`VEC_LO] = vec_value;
                    end
                end
            end
            RSP_VECTOR, RSP_RDERR:
            begin
                nxt_state = RSP_IDLE;
            end
            default:
            begin
                nxt_state = RSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff     <= RSP_IDLE;
            rsp_valid_ff <= 1'b0;
            rsp_rderr_ff <= 1'b0;
            rsp_data_ff  <= 32'h0;
        end
        else
        begin
            state_ff     <= nxt_state;
            rsp_valid_ff <= nxt_valid;
            rsp_rderr_ff <= nxt_rderr;
            rsp_data_ff  <= nxt_data;
        end
    end
endmodule : ident_responder

//--- verilog/err_irq_ctrl.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "err_irq_cfg.svh"
module err_irq_ctrl
    import err_irq_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [`ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata_ff,
    input  wire logic              err_irq_en,
    input  wire logic              err_log,
    input  wire logic              selftest_fail,
    input  wire logic              err_summary,
    input  wire logic [31:0]       bus_error_value,
    output logic                   err_interrupt_request_txn_ff,
    input  wire logic              ident_req,
    output logic                   ident_rsp_valid_ff,
    output logic                   ident_rderr_ff,
    output logic      [31:0]       ident_data_ff,
    output logic                   irq_ff
);
    logic              multi_error_irq_enable_ff;
    logic              vec_dis_ff;
    logic [13:0]       vector_ff;
    logic [`IRQ_W-1:0] irq_sts_ff;
    logic [`IRQ_W-1:0] irq_mask_ff;
    logic              nxt_multi_error_irq_enable;
    logic              nxt_vec_dis;
    logic [13:0]       nxt_vector;
    logic [`IRQ_W-1:0] nxt_irq_sts;
    logic [`IRQ_W-1:0] nxt_irq_mask;
    logic [31:0]       nxt_rdata;
    logic              nxt_err_interrupt_request_txn;
    logic              nxt_irq;
    logic              fire;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // A strobe only counts together with its own offset
    function automatic logic wr_hit(input logic wr, input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        wr_hit = wr && hit(a, off);
    endfunction : wr_hit

    function automatic logic rd_hit(input logic rd, input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        rd_hit = rd && hit(a, off);
    endfunction : rd_hit

    // Control register writes; reserved bits are not stored
    always_comb
    begin
        nxt_multi_error_irq_enable  = multi_error_irq_enable_ff;
        nxt_vec_dis = vec_dis_ff;
        if (wr_hit(reg_wr, reg_addr, `OFF_CTRL_STATUS))
        begin
            nxt_multi_error_irq_enable  = reg_wdata[`BIT_MULTI_ERROR_IRQ_ENABLE];
            nxt_vec_dis = reg_wdata[`BIT_VEC_DIS];
        end
    end

    // Return vector; bits outside the vector field are not stored
    always_comb
    begin
        nxt_vector = vector_ff;
        if (wr_hit(reg_wr, reg_addr, `OFF_RETURN_VECTOR))
        begin
            nxt_vector = reg_wdata[`VEC_HI:`VEC_LO];
        end
    end

    // Error interrupt issue policy; self-test failure is a separate input
    // that never reaches this decision
    always_comb
    begin
        fire = 1'b0;
        if (err_log && err_irq_en)
        begin
            if (multi_error_irq_enable_ff)
            begin
                fire = 1'b1;
            end
            else
            begin
                fire = !err_summary;
            end
        end
        nxt_err_interrupt_request_txn = fire;
    end

    // Sticky status: set beats read-clear
    always_comb
    begin
        nxt_irq_sts = irq_sts_ff;
        if (rd_hit(reg_rd, reg_addr, `OFF_IRQ_STATUS))
        begin
            nxt_irq_sts = '0;
        end
        nxt_irq_sts[`IRQ_ERR]   = nxt_irq_sts[`IRQ_ERR] | fire;
        nxt_irq_sts[`IRQ_IDENT] = nxt_irq_sts[`IRQ_IDENT] | ident_req;
    end

    // Mask shares the status offset and is write-only
    always_comb
    begin
        nxt_irq_mask = irq_mask_ff;
        if (wr_hit(reg_wr, reg_addr, `OFF_IRQ_MASK))
        begin
            nxt_irq_mask = reg_wdata[`IRQ_W-1:0];
        end
    end

    // Level output lines up with the registered status and mask
    always_comb
    begin
        nxt_irq = |(nxt_irq_sts & nxt_irq_mask);
    end

    // Read mux
    always_comb
    begin
        nxt_rdata = 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                `OFF_CTRL_STATUS:
                begin
                    nxt_rdata[`BIT_MULTI_ERROR_IRQ_ENABLE]  = multi_error_irq_enable_ff;
                    nxt_rdata[`BIT_VEC_DIS] = vec_dis_ff;
                end
                `OFF_RETURN_VECTOR:
                begin
                    nxt_rdata[`VEC_HI:`VEC_LO] = vector_ff;
                end
                `OFF_BUS_ERROR:
                begin
                    nxt_rdata = bus_error_value;
                end
                `OFF_IRQ_STATUS:
                begin
                    nxt_rdata[`IRQ_W-1:0] = irq_sts_ff;
                end
                default:
                begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            multi_error_irq_enable_ff  <= '0;
            vec_dis_ff <= '0;
        end
        else
        begin
            multi_error_irq_enable_ff  <= nxt_multi_error_irq_enable;
            vec_dis_ff <= nxt_vec_dis;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vector_ff <= '0;
        end
        else
        begin
            vector_ff <= nxt_vector;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_interrupt_request_txn_ff <= '0;
        end
        else
        begin
            err_interrupt_request_txn_ff <= nxt_err_interrupt_request_txn;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_sts_ff <= '0;
        end
        else
        begin
            irq_sts_ff <= nxt_irq_sts;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_mask_ff <= '0;
        end
        else
        begin
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_ff <= '0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_ff <= '0;
        end
        else
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    ident_responder u_ident
    (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .ident_req    (ident_req),
        .vec_dis      (vec_dis_ff),
        .vec_value    (vector_ff),
        .rsp_valid_ff (ident_rsp_valid_ff),
        .rsp_rderr_ff (ident_rderr_ff),
        .rsp_data_ff  (ident_data_ff)
    );
endmodule : err_irq_ctrl

//--- test/bus_node_model.sv
`timescale 1ns/100ps
module bus_node_model
(
    input wire logic core_clk,
    output logic     err_log,
    output logic     err_summary,
    output logic     ident_req
);
    initial
    begin
        err_log = 1'b0;
        err_summary = 1'b0;
        ident_req = 1'b0;
    end
    // Summary flag stays set from the first logged error until software clears it
    task automatic log_error();
        @(posedge core_clk);
        err_log <= 1'b1;
        @(posedge core_clk);
        err_log <= 1'b0;
        err_summary <= 1'b1;
    endtask : log_error
    task automatic clear_summary();
        @(posedge core_clk);
        err_summary <= 1'b0;
    endtask : clear_summary
    task automatic send_ident();
        @(posedge core_clk);
        ident_req <= 1'b1;
        @(posedge core_clk);
        ident_req <= 1'b0;
    endtask : send_ident
endmodule : bus_node_model

//--- test/err_irq_ctrl_assertions.sv
`timescale 1ns/100ps
`include "err_irq_cfg.svh"
module err_irq_ctrl_assertions
(
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic [31:0] ident_data_ff,
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        err_irq_en,
    input wire logic        err_log,
    input wire logic        selftest_fail,
    input wire logic        err_summary,
    input wire logic        err_interrupt_request_txn_ff,
    input wire logic        ident_req,
    input wire logic        ident_rsp_valid_ff,
    input wire logic        ident_rderr_ff
);
    logic        me_ff;
    logic        vd_ff;
    logic [13:0] vec_ff;
    wire         ev = err_log && err_irq_en;
    // Shadow of the control and vector fields as software wrote them
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
        begin
            me_ff <= 1'b0;
            vd_ff <= 1'b0;
            vec_ff <= 14'h0;
        end
        else if (reg_wr && reg_addr == 4'h0)
        begin
            me_ff <= reg_wdata[3];
            vd_ff <= reg_wdata[1];
        end
        else if (reg_wr && reg_addr == 4'h4)
            vec_ff <= reg_wdata[15:2];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_ask;
        ident_req && !ident_rsp_valid_ff;
    endsequence
    sequence s_refused;
        ident_rsp_valid_ff && ident_rderr_ff && ident_data_ff == 32'h0;
    endsequence
    sequence s_vec_ok;
        ident_rsp_valid_ff && !ident_rderr_ff && ident_data_ff == {16'h0, vec_ff, 2'b00};
    endsequence
    sequence s_ctrl_ok;
        reg_rdata_ff == {28'h0, me_ff, 1'b0, vd_ff, 1'b0};
    endsequence
    a_err_fire: assert property (ev && (me_ff || !err_summary) |=> err_interrupt_request_txn_ff)
        else $error("error interrupt missing");
    a_err_hold: assert property (ev && !me_ff && err_summary |=> !err_interrupt_request_txn_ff)
        else $error("second interrupt not held back");
    a_err_cause: assert property (!ev |=> !err_interrupt_request_txn_ff)
        else $error("interrupt without logged error");
    a_selftest_free: assert property (ev && selftest_fail && (me_ff || !err_summary) |=> err_interrupt_request_txn_ff)
        else $error("self-test failure changed the interrupt decision");
    a_vec_refuse: assert property (s_ask and vd_ff |=> s_refused)
        else $error("vector returned while disabled");
    a_vec_answer: assert property (s_ask and !vd_ff |=> s_vec_ok)
        else $error("wrong vector answer");
    a_ident_cause: assert property (!ident_req |=> !ident_rsp_valid_ff)
        else $error("answer without request");
    a_ctrl_read: assert property (reg_rd && reg_addr == 4'h0 |=> s_ctrl_ok)
        else $error("control read wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 0)
        else $error("read data outside read cycle");
endmodule : err_irq_ctrl_assertions
bind err_irq_ctrl err_irq_ctrl_assertions chk_u (.reg_addr, .reg_wdata, .reg_rdata_ff, .ident_data_ff, .core_clk,
    .resetn, .reg_wr, .reg_rd, .err_irq_en, .err_log, .selftest_fail, .err_summary, .err_interrupt_request_txn_ff, .ident_req,
    .ident_rsp_valid_ff, .ident_rderr_ff);

//--- test/err_irq_ctrl_tb.sv
`timescale 1ns/100ps
module err_irq_ctrl_tb;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata_ff, ident_data_ff;
    logic        core_clk, resetn, reg_wr, reg_rd, err_irq_en, selftest_fail, err_log, err_summary;
    logic        ident_req, err_interrupt_request_txn_ff, ident_rsp_valid_ff, ident_rderr_ff, irq_ff;
    int          failures, tests_run, cycles;
    err_irq_ctrl dut_u (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .err_irq_en,
        .err_log, .selftest_fail, .err_summary, .bus_error_value(32'h5A5A0F0F), .err_interrupt_request_txn_ff, .ident_req,
        .ident_rsp_valid_ff, .ident_rderr_ff, .ident_data_ff, .irq_ff);
    bus_node_model node_u (.core_clk, .err_log, .err_summary, .ident_req);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata_ff", e, reg_rdata_ff);
    endtask : rd
    task automatic err(input logic e);
        node_u.log_error();
        #1 chk("err_interrupt_request_txn_ff", e, err_interrupt_request_txn_ff);
    endtask : err
    task automatic ident(input logic e, input logic [31:0] d);
        node_u.send_ident();
        #1 chk("valid", 1, ident_rsp_valid_ff);
        chk("rderr", e, ident_rderr_ff);
        chk("data", d, ident_data_ff);
    endtask : ident
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            conclude();
        end
    end
    initial
    begin
        {resetn, reg_addr, reg_wdata, reg_wr, reg_rd, selftest_fail} = '0;
        err_irq_en = 1'b1;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(4'h0, 32'h0);
        wr(4'h0, 32'hFFFFFFFF);
        rd(4'h0, 32'h0000000A);
        rd(4'h1, 32'h0);
        $display("test registers ended");
        wr(4'h0, 32'h0);
        wr(4'hC, 32'h3);
        err(1'b1);
        err(1'b0);
        selftest_fail <= 1'b1;
        err(1'b0);
        wr(4'h0, 32'h8);
        err(1'b1);
        chk("irq_ff", 1, irq_ff);
        rd(4'h8, 32'h5A5A0F0F);
        rd(4'hC, 32'h1);
        rd(4'hC, 32'h0);
        chk("irq_ff", 0, irq_ff);
        err_irq_en <= 1'b0;
        err(1'b0);
        wr(4'hC, 32'h0);
        err_irq_en <= 1'b1;
        err(1'b1);
        rd(4'hC, 32'h1);
        chk("irq_ff", 0, irq_ff);
        wr(4'h0, 32'h0);
        node_u.clear_summary();
        err(1'b1);
        err(1'b0);
        rd(4'hC, 32'h1);
        $display("test errors ended");
        wr(4'h4, 32'hFFFFFFFF);
        rd(4'h4, 32'h0000FFFC);
        wr(4'h0, 32'h0);
        ident(1'b0, 32'h0000FFFC);
        ident(1'b0, 32'h0000FFFC);
        wr(4'h0, 32'h2);
        ident(1'b1, 32'h0);
        rd(4'hC, 32'h2);
        $display("test identify ended");
        @(posedge core_clk);
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        $display("test reset ended");
        conclude();
    end
endmodule : err_irq_ctrl_tb
